// File: design/sdcmd_device.sv
// Device-side command, bank, burst and data logic of a byte-wide SDRAM
`timescale 1ns/1ps
`include "sdcmd_regs.svh"
module sdcmd_device #(
	parameter int ROW_W = 12,
	parameter int COL_W = 10,
	parameter int DATA_W = 8,
	parameter int STORE_AW = 24
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Command pins
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic clk_en,
	// Address pins
	input wire logic bank_sel_lo,
	input wire logic bank_sel_hi,
	input wire logic [ROW_W-1:0] mux_address,
	// Data pins, split into in, out and enable
	input wire logic byte_mask,
	input wire logic [DATA_W-1:0] data_pins_in,
	output logic [DATA_W-1:0] data_pins_out,
	output logic data_pins_oe,
	// Status
	output sdcmd_pkg::sdcmd_pwr_e pwr_mode,
	output logic [ROW_W-1:0] refresh_row
);
	// Decode of the strobes sampled together
	function automatic sdcmd_pkg::sdcmd_cmd_e decode(
		input logic cs, input logic ras, input logic cas,
		input logic we);
		if (cs) begin
			return sdcmd_pkg::SDCMD_NOP;
		end
		case ({ras, cas, we})
			3'h3: return sdcmd_pkg::SDCMD_ACT;
			3'h5: return sdcmd_pkg::SDCMD_READ;
			3'h4: return sdcmd_pkg::SDCMD_WRITE;
			3'h2: return sdcmd_pkg::SDCMD_PRE;
			3'h1: return sdcmd_pkg::SDCMD_REF;
			3'h0: return sdcmd_pkg::SDCMD_MODE;
			3'h6: return sdcmd_pkg::SDCMD_STOP;
			default: return sdcmd_pkg::SDCMD_NOP;
		endcase
	endfunction

	// Column of burst step n: wrap mask limits the wrap
	function automatic logic [COL_W-1:0] step_col(
		input logic [COL_W-1:0] start, input logic [COL_W-1:0] n,
		input logic [COL_W-1:0] wrap, input logic il);
		if (il) begin
			return (start & ~wrap) | ((start ^ n) & wrap);
		end
		return (start & ~wrap) | ((start + n) & wrap);
	endfunction

	// Flat index; bank sits below the row, so a short store drops row bits
	function automatic logic [STORE_AW-1:0] idx(
		input logic [1:0] b, input logic [ROW_W-1:0] r,
		input logic [COL_W-1:0] c);
		logic [ROW_W+COL_W+1:0] f;
		f = {r, b, c};
		return f[STORE_AW-1:0];
	endfunction

	// Reset release through two flops
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Cell array; no reset, contents are undefined at power-up
	logic [DATA_W-1:0] mem [0:(1<<STORE_AW)-1];

	// Mode setting
	logic [2:0] bl_reg;
	logic order_reg;
	logic cl3_reg;
	logic swr_reg;
	// Bank bookkeeping, one entry per bank
	logic [3:0] open_reg;
	logic [ROW_W-1:0] row_reg [0:3];
	// Burst engine
	logic burst_reg;
	logic burst_wr_reg;
	logic burst_ap_reg;
	logic [1:0] burst_bank_reg;
	logic [COL_W-1:0] start_reg;
	logic [COL_W-1:0] cnt_reg;
	logic [COL_W-1:0] last_reg;
	logic [COL_W-1:0] wrap_reg;
	// Read pipeline and mask delay
	logic [1:0] rdv_reg;
	logic [DATA_W-1:0] rdd_reg [0:1];
	logic mask_reg;
	// Self-refresh timer
	logic [10:0] sref_cnt_reg;

	// Decoded inputs of this edge
	sdcmd_pkg::sdcmd_cmd_e cmd;
	logic run;
	logic [1:0] bank;
	logic is_col;
	logic [COL_W-1:0] col_now;
	logic [1:0] bank_now;
	logic acc_now;
	logic wr_now;
	logic burst_end;
	logic [COL_W-1:0] new_last;
	logic [COL_W-1:0] new_wrap;

	// Commands act only while clocking runs
	assign run = clk_en && (pwr_mode == sdcmd_pkg::SDCMD_RUN);
	assign cmd = run ? decode(cs_n, ras_n, cas_n, we_n)
		: sdcmd_pkg::SDCMD_NOP;
	assign bank = {bank_sel_hi, bank_sel_lo};
	// A column command to a closed bank is dropped
	assign is_col = ((cmd == sdcmd_pkg::SDCMD_READ)
		|| (cmd == sdcmd_pkg::SDCMD_WRITE)) && open_reg[bank];

	// Burst length and wrap mask from the mode setting
	always_comb begin
		new_wrap = '0;
		case (bl_reg)
			`SDC_BL_2: new_wrap = COL_W'(1);
			`SDC_BL_4: new_wrap = COL_W'(3);
			`SDC_BL_8: new_wrap = COL_W'(7);
			`SDC_BL_ROW: new_wrap = '1;
			default: new_wrap = '0;
		endcase
		// Last count equals the wrap mask; single writes cut it to zero
		new_last = new_wrap;
		if (swr_reg && cmd == sdcmd_pkg::SDCMD_WRITE) begin
			new_last = '0;
		end
	end

	// Access of this edge: a new column command wins over the burst
	always_comb begin
		if (is_col) begin
			col_now = mux_address[COL_W-1:0];
			bank_now = bank;
			acc_now = 1'b1;
			wr_now = (cmd == sdcmd_pkg::SDCMD_WRITE);
		end else begin
			col_now = step_col(start_reg, cnt_reg, wrap_reg,
				order_reg);
			bank_now = burst_bank_reg;
			acc_now = run && burst_reg;
			wr_now = burst_wr_reg;
		end
	end

	// Full-row bursts never end by count
	assign burst_end = (cnt_reg == last_reg) && (bl_reg != `SDC_BL_ROW);
	// Mode setting register
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			bl_reg <= `SDC_RST_BL;
			order_reg <= `SDC_RST_ORDER;
			cl3_reg <= `SDC_RST_CL3;
			swr_reg <= `SDC_RST_SWR;
		end else if (cmd == sdcmd_pkg::SDCMD_MODE) begin
			bl_reg <= mux_address[`SDC_MODE_BL_MSB:`SDC_MODE_BL_LSB];
			order_reg <= mux_address[`SDC_MODE_ORDER_BIT];
			cl3_reg <= (mux_address[`SDC_MODE_CL_MSB:`SDC_MODE_CL_LSB]
				== `SDC_CL_3);
			swr_reg <= mux_address[`SDC_MODE_SWR_BIT];
		end
	end

	// Bank open state and rows, each bank on its own
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			open_reg <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				row_reg[i] <= '0;
			end
		end else begin
			if (cmd == sdcmd_pkg::SDCMD_PRE) begin
				if (mux_address[`SDC_AP_BIT]) begin
					open_reg <= 4'h0;
				end else begin
					open_reg[bank] <= 1'b0;
				end
			end
			// Auto precharge at the last word of the access
			if (is_col && mux_address[`SDC_AP_BIT]
				&& new_last == '0) begin
				open_reg[bank] <= 1'b0;
			end else if (!is_col && acc_now && burst_end
				&& burst_ap_reg) begin
				open_reg[burst_bank_reg] <= 1'b0;
			end
			// Activate comes last, so an open wins over a close
			if (cmd == sdcmd_pkg::SDCMD_ACT) begin
				open_reg[bank] <= 1'b1;
				row_reg[bank] <= mux_address;
			end
		end
	end

	// Burst counter; a terminate or precharge of its bank stops it
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			burst_reg <= 1'b0;
			burst_wr_reg <= 1'b0;
			burst_ap_reg <= 1'b0;
			burst_bank_reg <= 2'h0;
			start_reg <= '0;
			cnt_reg <= '0;
			last_reg <= '0;
			wrap_reg <= '0;
		end else if (is_col) begin
			burst_reg <= (new_last != '0);
			burst_wr_reg <= wr_now;
			burst_ap_reg <= mux_address[`SDC_AP_BIT];
			burst_bank_reg <= bank;
			start_reg <= mux_address[COL_W-1:0];
			cnt_reg <= COL_W'(1);
			last_reg <= new_last;
			wrap_reg <= new_wrap;
		end else if (cmd == sdcmd_pkg::SDCMD_STOP
			|| (cmd == sdcmd_pkg::SDCMD_PRE
			&& (mux_address[`SDC_AP_BIT] || bank == burst_bank_reg))) begin
			burst_reg <= 1'b0;
		end else if (acc_now) begin
			cnt_reg <= cnt_reg + COL_W'(1);
			if (burst_end) begin
				burst_reg <= 1'b0;
			end
		end
	end

	// Writes; mask high blocks the word of the same edge
	always_ff @(posedge sys_clk) begin
		if (acc_now && wr_now && !byte_mask) begin
			mem[idx(bank_now, row_reg[bank_now], col_now)]
				<= data_pins_in;
		end
	end

	// Read pipeline; frozen while clocking is suspended
	always_ff @(posedge sys_clk) begin
		if (run) begin
			rdd_reg[0] <= mem[idx(bank_now, row_reg[bank_now], col_now)];
			rdd_reg[1] <= rdd_reg[0];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rdv_reg <= 2'h0;
		end else if (run) begin
			rdv_reg <= {rdv_reg[0], acc_now && !wr_now};
		end
	end

	// Mask delay: high at edge n floats the word shown after n+1
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			mask_reg <= 1'b0;
		end else if (clk_en) begin
			mask_reg <= byte_mask;
		end
	end

	// Output stage picks the stage that gives latency two or three
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			data_pins_out <= '0;
			data_pins_oe <= 1'b0;
		end else if (run) begin
			data_pins_out <= cl3_reg ? rdd_reg[1] : rdd_reg[0];
			data_pins_oe <= !mask_reg
				&& (cl3_reg ? rdv_reg[1] : rdv_reg[0]);
		end else if (pwr_mode != sdcmd_pkg::SDCMD_SUSP) begin
			// Suspend holds the pins, but its entry edge has already cleared data_pins_oe; other low-power states float
			data_pins_oe <= 1'b0;
		end
	end

	// Clocking state chosen by what is going on at clock enable low
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pwr_mode <= sdcmd_pkg::SDCMD_RUN;
		end else begin
			case (pwr_mode)
				sdcmd_pkg::SDCMD_RUN: begin
					if (!clk_en) begin
						if (decode(cs_n, ras_n, cas_n, we_n)
							== sdcmd_pkg::SDCMD_REF) begin
							pwr_mode <= sdcmd_pkg::SDCMD_SREF;
						end else if (burst_reg || rdv_reg != 2'h0) begin
							pwr_mode <= sdcmd_pkg::SDCMD_SUSP;
						end else begin
							pwr_mode <= sdcmd_pkg::SDCMD_PDN;
						end
					end
				end
				default: begin
					if (clk_en) begin
						pwr_mode <= sdcmd_pkg::SDCMD_RUN;
					end
				end
			endcase
		end
	end
	// Refresh row counter: driven by commands or by own timer
	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			refresh_row <= '0;
			sref_cnt_reg <= 11'h000;
		end else if (pwr_mode == sdcmd_pkg::SDCMD_SREF) begin
			// Self refresh spaces rows evenly over the window
			if (sref_cnt_reg == 11'(`SDC_REF_CYC - 1)) begin
				sref_cnt_reg <= 11'h000;
				refresh_row <= refresh_row + ROW_W'(1);
			end else begin
				sref_cnt_reg <= sref_cnt_reg + 11'h001;
			end
		end else begin
			sref_cnt_reg <= 11'h000;
			if (cmd == sdcmd_pkg::SDCMD_REF) begin
				refresh_row <= refresh_row + ROW_W'(1);
			end
		end
	end
endmodule

// File: design/sdcmd_pkg.sv
// Types of the synchronous DRAM command interface
package sdcmd_pkg;
	// Decoded command
	typedef enum logic [2:0] {
		SDCMD_NOP, SDCMD_ACT, SDCMD_READ, SDCMD_WRITE,
		SDCMD_PRE, SDCMD_REF, SDCMD_MODE, SDCMD_STOP
	} sdcmd_cmd_e;
	// Clocking state
	typedef enum logic [1:0] {
		SDCMD_RUN, SDCMD_PDN, SDCMD_SUSP, SDCMD_SREF
	} sdcmd_pwr_e;
endpackage

// File: design/sdcmd_regs.svh
// Constants of the synchronous DRAM command interface
`ifndef SDCMD_REGS_SVH
`define SDCMD_REGS_SVH
// Mode setting fields on the address pins
`define SDC_MODE_BL_LSB 0
`define SDC_MODE_BL_MSB 2
`define SDC_MODE_ORDER_BIT 3
`define SDC_MODE_CL_LSB 4
`define SDC_MODE_CL_MSB 6
`define SDC_MODE_SWR_BIT 9
// Burst length codes and the latency 3 code
`define SDC_BL_1 3'h0
`define SDC_BL_2 3'h1
`define SDC_BL_4 3'h2
`define SDC_BL_8 3'h3
`define SDC_BL_ROW 3'h7
`define SDC_CL_3 3'h3
// Auto precharge / all banks flag position
`define SDC_AP_BIT 10
// Reset values of the mode setting
`define SDC_RST_BL 3'h0
`define SDC_RST_ORDER 1'h0
`define SDC_RST_CL3 1'h1
`define SDC_RST_SWR 1'h0
// Refresh spacing used during self-refresh
`define SDC_CLK_NS 10
`define SDC_REF_WIN_MS 64
`define SDC_REF_ROWS 4096
`define SDC_REF_CYC ((`SDC_REF_WIN_MS * 1000000) / `SDC_REF_ROWS / `SDC_CLK_NS)
`endif

// File: verif/sdcmd_ctl_model.sv
// Memory controller model driving the SDRAM command pins
`timescale 1ns/1ps
module sdcmd_ctl_model (
	// Clock
	input wire logic sys_clk,
	// Command, address and data pins
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic clk_en,
	output logic bank_sel_lo,
	output logic bank_sel_hi,
	output logic [11:0] mux_address,
	output logic byte_mask,
	output logic [7:0] data_pins_in
);
	// 20 ns waits rounded up to whole cycles
	localparam int TWAIT = 2;
	// Idle pins at time zero
	initial begin
		{cs_n, ras_n, cas_n, we_n, clk_en} = 5'h1F;
		{bank_sel_hi, bank_sel_lo, byte_mask} = 3'h0;
		mux_address = 12'h000;
		data_pins_in = 8'h00;
	end
	// One edge of pins, set just after the falling edge
	task automatic drive(input logic s, input logic [2:0] c,
		input logic [1:0] b, input logic [11:0] a, input logic m,
		input logic [7:0] d);
		@(negedge sys_clk);
		cs_n = s;
		{ras_n, cas_n, we_n} = c;
		{bank_sel_hi, bank_sel_lo} = b;
		mux_address = a;
		byte_mask = m;
		data_pins_in = d;
	endtask
	// Deselect; unused lines flip so stale values never look valid
	task automatic nop(input logic m, input logic [7:0] d);
		drive(1'b1, 3'h7, ~{bank_sel_hi, bank_sel_lo}, ~mux_address, m, d);
	endtask
	// Clock enable, changed in the current time step
	task automatic set_cke(input logic v);
		clk_en = v;
	endtask
	// Open a row, then wait before any column access
	task automatic act(input logic [1:0] b, input logic [11:0] r);
		drive(1'b0, 3'h3, b, r, 1'b0, ~data_pins_in);
		repeat (TWAIT) nop(1'b0, ~data_pins_in);
	endtask
	// Close all banks first, so the mode is only set while idle
	task automatic set_mode(input logic [11:0] m);
		drive(1'b0, 3'h2, 2'h0, 12'h400, 1'b0, ~data_pins_in);
		repeat (TWAIT) nop(1'b0, ~data_pins_in);
		drive(1'b0, 3'h0, 2'h0, m, 1'b0, ~data_pins_in);
		repeat (TWAIT) nop(1'b0, ~data_pins_in);
	endtask
	// One row refresh, then the refresh cycle time
	task automatic refresh;
		drive(1'b0, 3'h1, 2'h0, 12'h000, 1'b0, ~data_pins_in);
		repeat (7) nop(1'b0, ~data_pins_in);
	endtask
endmodule

// File: verif/sdcmd_device_chk.sv
// Port checker of the SDRAM command interface
`timescale 1ns/1ps
module sdcmd_device_chk #(
	parameter int ROW_W = 12
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Command pins
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic clk_en,
	input wire logic byte_mask,
	input wire logic [ROW_W-1:0] mux_address,
	// Outputs watched
	input wire logic data_pins_oe,
	input wire sdcmd_pkg::sdcmd_pwr_e pwr_mode,
	input wire logic [ROW_W-1:0] refresh_row
);
	// Running state and the command taken at this edge
	wire logic run = pwr_mode == sdcmd_pkg::SDCMD_RUN;
	wire logic take = !cs_n && clk_en && run;
	wire logic [2:0] code = {ras_n, cas_n, we_n};
	// Latency copy; only a mode set changes it, so reset gives three
	logic cl3_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cl3_reg <= 1'b1;
		end else if (take && code == 3'h0) begin
			cl3_reg <= mux_address[6:4] == 3'h3;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_cl2;
		take && code == 3'h5 && !cl3_reg && !byte_mask
		##1 clk_en && (cs_n || code == 3'h7) |=> data_pins_oe;
	endproperty
	a_cl2: assert property (p_cl2) else $error("late read word");
	property p_cl3;
		take && code == 3'h5 && cl3_reg
		##1 clk_en && !byte_mask && (cs_n || code == 3'h7)
		##1 clk_en |=> data_pins_oe;
	endproperty
	a_cl3: assert property (p_cl3) else $error("late word");
	property p_mask;
		byte_mask && clk_en && run ##1 clk_en |=> !data_pins_oe;
	endproperty
	a_mask: assert property (p_mask) else $error("mask ignored");
	property p_sref;
		!cs_n && !clk_en && run && code == 3'h1
		|=> pwr_mode == sdcmd_pkg::SDCMD_SREF;
	endproperty
	a_sref: assert property (p_sref) else $error("no self refresh");
	property p_leave;
		run && !clk_en |=> !run;
	endproperty
	a_leave: assert property (p_leave) else $error("clock not held");
	property p_wake;
		!run && clk_en |=> run;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake up");
	property p_float;
		pwr_mode inside {sdcmd_pkg::SDCMD_PDN, sdcmd_pkg::SDCMD_SREF}
		|-> !data_pins_oe;
	endproperty
	a_float: assert property (p_float) else $error("driven asleep");
	property p_row;
		$changed(refresh_row) |-> refresh_row == $past(refresh_row) + 1'b1;
	endproperty
	a_row: assert property (p_row) else $error("row skipped");
endmodule
bind sdcmd_device sdcmd_device_chk #(.ROW_W(ROW_W)) i_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
	.cas_n(cas_n), .we_n(we_n), .clk_en(clk_en), .byte_mask(byte_mask),
	.mux_address(mux_address), .data_pins_oe(data_pins_oe),
	.pwr_mode(pwr_mode), .refresh_row(refresh_row));

// File: verif/tb_sdcmd_device.sv
// Self-checking testbench of the SDRAM command interface
`timescale 1ns/1ps
module tb_sdcmd_device;
	// Pins
	logic sys_clk, rst_n, cs_n, ras_n, cas_n, we_n, clk_en, bsl, bsh, bm, oe;
	logic [11:0] adr, refresh_row;
	logic [7:0] din, dout;
	sdcmd_pkg::sdcmd_pwr_e pwr_mode;
	// Counters and expected cells of bank 1 row 5
	int failures, num_checks;
	logic [7:0] mem [0:1023];
	sdcmd_ctl_model i_ctl (.sys_clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .clk_en(clk_en), .bank_sel_lo(bsl),
		.bank_sel_hi(bsh), .mux_address(adr), .byte_mask(bm),
		.data_pins_in(din));
	sdcmd_device #(.STORE_AW(16)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.clk_en(clk_en), .bank_sel_lo(bsl), .bank_sel_hi(bsh),
		.mux_address(adr), .byte_mask(bm), .data_pins_in(din),
		.data_pins_out(dout), .data_pins_oe(oe), .pwr_mode(pwr_mode),
		.refresh_row(refresh_row));
	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Column of word k in a burst of four
	function automatic logic [9:0] col_at(logic [9:0] c, int k, logic il);
		return il ? c ^ 10'(k) : {c[9:2], 2'(c[1:0] + 2'(k))};
	endfunction
	// Sequential write burst of four, one mask bit per word
	task automatic wr4(logic [9:0] c, logic [7:0] v, logic [3:0] m);
		for (int k = 0; k < 4; k++) begin
			if (k == 0) i_ctl.drive(1'b0, 3'h4, 2'h1, {2'h0, c}, m[0], v);
			else i_ctl.nop(m[k], v + 8'(k));
			if (!m[k]) mem[col_at(c, k, 1'b0)] = v + 8'(k);
		end
	endtask
	// Read burst of four; a mask lands two edges before its word
	task automatic rd4(logic [9:0] c, int lat, logic il, logic [3:0] m);
		int k;
		logic mk;
		for (int t = 0; t <= lat + 4; t++) begin
			k = t - lat;
			mk = (k >= -2 && k < 2) ? m[k + 2] : 1'b0;
			if (t == 0) i_ctl.drive(1'b0, 3'h5, 2'h1, {2'h0, c}, mk, 8'h00);
			else i_ctl.nop(mk, 8'(t));
			if (k >= 0 && k < 4) begin
				check("read_oe", 16'(oe), 16'(!m[k]));
				if (!m[k]) check("read_data", 16'(dout),
					16'(mem[col_at(c, k, il)]));
			end else if (k == 4) check("burst_end", 16'(oe), 16'h0);
		end
	endtask
	// Writes back to back, a masked word, then masked and plain reads
	task automatic s_burst;
		i_ctl.set_mode(12'h022);
		i_ctl.act(2'h1, 12'h005);
		wr4(10'h006, 8'h10, 4'h0);
		wr4(10'h006, 8'h40, 4'h4);
		rd4(10'h006, 2, 1'b0, 4'h0);
		rd4(10'h006, 2, 1'b0, 4'h2);
		i_ctl.set_mode(12'h03A);
		i_ctl.act(2'h1, 12'h005);
		rd4(10'h005, 3, 1'b1, 4'h0);
		rd4(10'h005, 3, 1'b1, 4'h8);
	endtask
	// A new column every cycle with single-word bursts
	task automatic s_random;
		logic [9:0] c;
		i_ctl.set_mode(12'h020);
		i_ctl.act(2'h1, 12'h005);
		for (int t = 0; t < 7; t++) begin
			c = 10'h004 + 10'((7 - 3 * t) & 3);
			if (t < 4) i_ctl.drive(1'b0, 3'h5, 2'h1, {2'h0, c}, 1'b0, 8'h00);
			else i_ctl.nop(1'b0, 8'(t));
			c = 10'h004 + 10'((13 - 3 * t) & 3);
			if (t >= 2 && t < 6) check("col_data", 16'(dout),
				16'(mem[c]));
			if (t == 6) check("single_end", 16'(oe), 16'h0);
		end
	endtask
	// Burst reads with single writes: only the first word is stored
	task automatic s_single;
		i_ctl.set_mode(12'h23A);
		i_ctl.act(2'h1, 12'h005);
		i_ctl.drive(1'b0, 3'h4, 2'h1, 12'h005, 1'b0, 8'h77);
		mem[5] = 8'h77;
		repeat (3) i_ctl.nop(1'b0, 8'h99);
		rd4(10'h005, 3, 1'b1, 4'h0);
	endtask
	// Burst stop in bank 3, then a read while deselected
	task automatic s_stop;
		i_ctl.set_mode(12'h023);
		i_ctl.act(2'h3, 12'h005);
		i_ctl.drive(1'b0, 3'h5, 2'h3, 12'h000, 1'b0, 8'h00);
		i_ctl.drive(1'b0, 3'h6, 2'h3, 12'h0FF, 1'b0, 8'h00);
		i_ctl.nop(1'b0, 8'h00);
		check("stop_word", 16'(oe), 16'h1);
		repeat (2) i_ctl.nop(1'b0, 8'h00);
		check("stopped", 16'(oe), 16'h0);
		i_ctl.drive(1'b1, 3'h5, 2'h3, 12'h004, 1'b0, 8'h00);
		for (int t = 0; t < 5; t++) begin
			i_ctl.nop(1'b0, 8'h00);
			check("deselected", 16'(oe), 16'h0);
		end
	endtask
	// Power-down, refresh and self-refresh
	task automatic s_power;
		logic [11:0] r;
		i_ctl.set_mode(12'h020);
		i_ctl.nop(1'b0, 8'h00);
		i_ctl.set_cke(1'b0);
		i_ctl.nop(1'b0, 8'h00);
		check("asleep", 16'(pwr_mode), 16'(sdcmd_pkg::SDCMD_PDN));
		i_ctl.set_cke(1'b1);
		i_ctl.nop(1'b0, 8'h00);
		check("awake", 16'(pwr_mode), 16'(sdcmd_pkg::SDCMD_RUN));
		r = refresh_row;
		i_ctl.refresh();
		check("ref_row", 16'(refresh_row), 16'(r + 12'h001));
		i_ctl.drive(1'b0, 3'h1, 2'h0, 12'h000, 1'b0, 8'h00);
		i_ctl.set_cke(1'b0);
		repeat (1600) i_ctl.nop(1'b0, 8'h00);
		check("sref", 16'(pwr_mode), 16'(sdcmd_pkg::SDCMD_SREF));
		check("sref_step", 16'(refresh_row), 16'(r + 12'h002));
		i_ctl.set_cke(1'b1);
		repeat (2) i_ctl.nop(1'b0, 8'h00);
		check("sref_exit", 16'(pwr_mode), 16'(sdcmd_pkg::SDCMD_RUN));
	endtask
	// Reset in mid-run clears the row counter and output enable
	task automatic s_reset;
		@(negedge sys_clk);
		rst_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("rst_row", 16'(refresh_row), 16'h0);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		check("rst_mode", 16'(pwr_mode), 16'(sdcmd_pkg::SDCMD_RUN));
		check("rst_oe", 16'(oe), 16'h0);
	endtask
	// Guard against a hang
	initial begin
		#300000;
		failures++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		failures = 0;
		num_checks = 0;
		rst_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		check("reset_oe", 16'(oe), 16'h0);
		check("reset_row", 16'(refresh_row), 16'h0);
		s_burst();
		s_random();
		s_single();
		s_stop();
		s_power();
		s_reset();
		tally_and_finish();
	end
endmodule
